// ===== rtl/bsl_indicator.sv
// Board diagnostic and per-channel interface indicator driver.
`timescale 1ns/1ns
// Function
// - Reset puts every channel in high impedance.
// - Show running test code, bit0 on indicator0.
// - On failure halt, keep failing code shown.
// - After pass, rotate one lit indicator.
// - Driver loaded: stop rotation, heartbeat toggles.
// - Run phase: command busy indicator lit.
// - Run phase: unacknowledged interrupt indicator lit.
// - Async rx/tx lit for any channel.
// - Sync rx/tx lit for any channel.
// - Receive error lit for any channel error.
// - Codes 01h..1Ah processor checks; 01h flags.
// - Memory C0h, watchdog C2h, bus C4h.
// - Peripheral codes 81h through 8Fh.
// - Interface selection encodes eight channel indicators.
// - One bit lights, zero bit darkens.
// - Channels dark until driver started.
module bsl_indicator
   import bsl_pkg::*;
#(
   parameter int unsigned NCH = BSL_NCH,
   parameter int unsigned BEAT_CYC = BSL_BEAT_CYC,
   parameter int unsigned ROT_CYC = BSL_ROT_CYC
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Self-test sequencer report.
   input wire bsl_test_t i_test,
   // Host driver and run status.
   input wire logic i_driver_up,
   input wire logic i_cmd_busy,
   input wire logic i_irq_pending,
   // Channel activity and interface selection.
   input wire bsl_chan_act_t [NCH-1:0] i_chan_act,
   input wire bsl_if_t [NCH-1:0] i_chan_if,
   // Indicator outputs.
   output logic [7:0] o_diag_led,
   output logic [NCH-1:0][7:0] o_chan_led,
   output logic [NCH-1:0] o_chan_hiz
);
   bsl_state_t state_r;
   bsl_state_t state_nxt;
   logic [7:0] diag_r;
   logic [7:0] diag_nxt;
   logic [7:0] rot_r;
   logic [7:0] rot_nxt;
   logic beat_r;
   logic beat_nxt;
   logic [31:0] pre_r;
   logic [31:0] pre_nxt;
   logic [31:0] limit;
   logic pre_tick;
   logic [NCH-1:0][7:0] chan_r;
   logic [NCH-1:0][7:0] chan_nxt;
   logic [NCH-1:0] hiz_r;
   logic [NCH-1:0] hiz_nxt;
   bsl_chan_act_t any_act;
   logic [7:0] status;
   logic enter_rot;
   logic enter_run;

   // Activity is ORed over channels so one busy port is enough to light a lamp.
   always_comb begin
      any_act = '0;
      for (int i = 0; i < NCH; i++) begin
         any_act = any_act | i_chan_act[i];
      end
   end

   // Run-phase status lamps, heartbeat bit filled in later.
   always_comb begin
      status = '0;
      status[BSL_BIT_CMD] = i_cmd_busy;
      status[BSL_BIT_IRQ] = i_irq_pending;
      status[BSL_BIT_ARX] = any_act.async_rx;
      status[BSL_BIT_ATX] = any_act.async_tx;
      status[BSL_BIT_SRX] = any_act.sync_rx;
      status[BSL_BIT_STX] = any_act.sync_tx;
      status[BSL_BIT_RXERR] = any_act.rx_error;
   end

   // Phase sequencer.
   always_comb begin
      state_nxt = state_r;
      enter_rot = 1'b0;
      enter_run = 1'b0;
      case (state_r)
         BSL_ST_TEST: begin
            if (i_test.fail) begin
               state_nxt = BSL_ST_HALT;
            end else if (i_test.done) begin
               state_nxt = BSL_ST_ROTATE;
               enter_rot = 1'b1;
            end
         end
         BSL_ST_HALT: begin
            // Only a reset leaves a halted self-test.
            state_nxt = BSL_ST_HALT;
         end
         BSL_ST_ROTATE: begin
            if (i_driver_up) begin
               state_nxt = BSL_ST_RUN;
               enter_run = 1'b1;
            end
         end
         BSL_ST_RUN: begin
            state_nxt = BSL_ST_RUN;
         end
         default: begin
            state_nxt = BSL_ST_TEST;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= BSL_ST_TEST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // One prescaler serves both phases, since rotation and heartbeat never overlap.
   always_comb begin
      limit = (state_r == BSL_ST_RUN) ? BEAT_CYC : ROT_CYC;
      pre_tick = (pre_r >= limit - 32'h1);
      pre_nxt = pre_r;
      if (enter_rot || enter_run) begin
         pre_nxt = 32'h0;
      end else if ((state_r == BSL_ST_ROTATE) || (state_r == BSL_ST_RUN)) begin
         if (pre_tick) begin
            pre_nxt = 32'h0;
         end else begin
            pre_nxt = pre_r + 32'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pre_r <= 32'h0;
      end else begin
         pre_r <= pre_nxt;
      end
   end

   // Rotation pattern.
   always_comb begin
      rot_nxt = rot_r;
      if (enter_rot) begin
         rot_nxt = BSL_ROT_INIT;
      end else if ((state_r == BSL_ST_ROTATE) && !enter_run && pre_tick) begin
         rot_nxt = {rot_r[6:0], rot_r[7]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rot_r <= BSL_ROT_INIT;
      end else begin
         rot_r <= rot_nxt;
      end
   end

   // Heartbeat starts lit so the run phase is visible at once.
   always_comb begin
      beat_nxt = beat_r;
      if (enter_run) begin
         beat_nxt = 1'b1;
      end else if ((state_r == BSL_ST_RUN) && pre_tick) begin
         beat_nxt = ~beat_r;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         beat_r <= 1'b0;
      end else begin
         beat_r <= beat_nxt;
      end
   end

   // Diagnostic lamps.
   always_comb begin
      diag_nxt = diag_r;
      case (state_r)
         BSL_ST_TEST: begin
            // Codes are passed through as given; the sequencer owns their meaning.
            if (i_test.running) begin
               diag_nxt = i_test.code;
            end
            if (i_test.fail) begin
               diag_nxt = i_test.code;
            end else if (enter_rot) begin
               diag_nxt = BSL_ROT_INIT;
            end
         end
         BSL_ST_HALT: begin
            diag_nxt = diag_r;
         end
         BSL_ST_ROTATE: begin
            if (!enter_run) begin
               diag_nxt = rot_nxt;
            end
         end
         BSL_ST_RUN: begin
            diag_nxt = status;
            diag_nxt[BSL_BIT_BEAT] = beat_nxt;
         end
         default: begin
            diag_nxt = diag_r;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         diag_r <= BSL_CODE_NONE;
      end else begin
         diag_r <= diag_nxt;
      end
   end

   // Per-channel interface lamps; held dark and in high impedance until the driver runs.
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      always_comb begin
         chan_nxt[c] = BSL_PAT_HIZ;
         hiz_nxt[c] = 1'b1;
         if (state_r == BSL_ST_RUN) begin
            case (i_chan_if[c])
               BSL_IF_RS232: begin
                  chan_nxt[c] = BSL_PAT_RS232;
               end
               BSL_IF_V35: begin
                  chan_nxt[c] = BSL_PAT_V35;
               end
               BSL_IF_RS422: begin
                  chan_nxt[c] = BSL_PAT_RS422;
               end
               BSL_IF_RS485: begin
                  chan_nxt[c] = BSL_PAT_RS485;
               end
               default: begin
                  chan_nxt[c] = BSL_PAT_HIZ;
               end
            endcase
            // Unknown selections fall back to high impedance as well as dark lamps.
            hiz_nxt[c] = (chan_nxt[c] == BSL_PAT_HIZ);
         end
      end
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            chan_r[c] <= BSL_PAT_HIZ;
            hiz_r[c] <= 1'b1;
         end else begin
            chan_r[c] <= chan_nxt[c];
            hiz_r[c] <= hiz_nxt[c];
         end
      end
   end

   assign o_diag_led = diag_r;
   assign o_chan_led = chan_r;
   assign o_chan_hiz = hiz_r;
endmodule : bsl_indicator

// ===== rtl/bsl_pkg.sv
// Package of constants and types for the board status indicator block.
package bsl_pkg;
   localparam int unsigned BSL_CLK_HZ = 125000000;
   localparam int unsigned BSL_BEAT_MS = 500;
   localparam int unsigned BSL_BEAT_CYC = BSL_CLK_HZ / 1000 * BSL_BEAT_MS;
   localparam int unsigned BSL_ROT_MS = 125;
   localparam int unsigned BSL_ROT_CYC = BSL_CLK_HZ / 1000 * BSL_ROT_MS;
   localparam int unsigned BSL_NCH = 4;
   localparam logic [7:0] BSL_CODE_NONE = 8'h00;
   localparam logic [7:0] BSL_CODE_FLAGS = 8'h01;
   localparam logic [7:0] BSL_CODE_CPU_LAST = 8'h1A;
   localparam logic [7:0] BSL_CODE_MEM = 8'hC0;
   localparam logic [7:0] BSL_CODE_WDOG = 8'hC2;
   localparam logic [7:0] BSL_CODE_BUS = 8'hC4;
   localparam logic [7:0] BSL_CODE_PER_FIRST = 8'h81;
   localparam logic [7:0] BSL_CODE_PER_LAST = 8'h8F;
   localparam logic [7:0] BSL_ROT_INIT = 8'h01;
   localparam logic [7:0] BSL_PAT_HIZ = 8'h00;
   localparam logic [7:0] BSL_PAT_RS232 = 8'h22;
   localparam logic [7:0] BSL_PAT_V35 = 8'hEE;
   localparam logic [7:0] BSL_PAT_RS422 = 8'h44;
   localparam logic [7:0] BSL_PAT_RS485 = 8'h05;
   localparam int unsigned BSL_BIT_BEAT = 0;
   localparam int unsigned BSL_BIT_CMD = 1;
   localparam int unsigned BSL_BIT_IRQ = 2;
   localparam int unsigned BSL_BIT_ARX = 3;
   localparam int unsigned BSL_BIT_ATX = 4;
   localparam int unsigned BSL_BIT_SRX = 5;
   localparam int unsigned BSL_BIT_STX = 6;
   localparam int unsigned BSL_BIT_RXERR = 7;

   typedef enum logic [2:0] {
      BSL_IF_HIZ = 3'b000,
      BSL_IF_RS232 = 3'b001,
      BSL_IF_V35 = 3'b010,
      BSL_IF_RS422 = 3'b011,
      BSL_IF_RS485 = 3'b100
   } bsl_if_t;

   typedef enum logic [1:0] {
      BSL_ST_TEST = 2'b00,
      BSL_ST_HALT = 2'b01,
      BSL_ST_ROTATE = 2'b10,
      BSL_ST_RUN = 2'b11
   } bsl_state_t;

   // Per-channel activity carried as one bundle.
   typedef struct packed {
      logic async_rx;
      logic async_tx;
      logic sync_rx;
      logic sync_tx;
      logic rx_error;
   } bsl_chan_act_t;

   // Self-test report from the on-board test sequencer.
   typedef struct packed {
      logic running;
      logic fail;
      logic done;
      logic [7:0] code;
   } bsl_test_t;
endpackage : bsl_pkg

// ===== dv/bsl_indicator_properties.sv
// Port-level checker for the indicator block.
`timescale 1ns/1ns
module bsl_chk
   import bsl_pkg::*;
#(
   parameter int unsigned NCH = BSL_NCH,
   parameter int unsigned BEAT_CYC = BSL_BEAT_CYC,
   parameter int unsigned ROT_CYC = BSL_ROT_CYC
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Watched ports.
   input wire bsl_test_t i_test,
   input wire logic i_driver_up,
   input wire logic i_cmd_busy,
   input wire logic i_irq_pending,
   input wire bsl_chan_act_t [NCH-1:0] i_chan_act,
   input wire logic [7:0] o_diag_led,
   input wire logic [NCH-1:0][7:0] o_chan_led,
   input wire logic [NCH-1:0] o_chan_hiz
);
   localparam int ROT_MAX = ROT_CYC + 1;
   logic test_r;
   int unsigned run_r;
   logic beat_r;
   logic [4:0] any;
   int unsigned cnt_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   always_comb begin
      any = '0;
      for (int c = 0; c < NCH; c++) any = any | i_chan_act[c];
   end
   // Channel 0 leaving high impedance marks the run phase, so the bench keeps it selected.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         test_r <= 1'b1;
         beat_r <= 1'b0;
         cnt_r <= 0;
         run_r <= 0;
      end else begin
         run_r <= o_chan_hiz[0] ? 0 : ((run_r < 2 * BEAT_CYC) ? run_r + 1 : run_r);
         test_r <= test_r && !i_test.fail && !i_test.done;
         beat_r <= o_diag_led[0];
         cnt_r <= (beat_r != o_diag_led[0]) ? 0 : cnt_r + 1;
      end
   end
   sequence s_fail; test_r && i_test.fail; endsequence
   sequence s_pass; test_r && i_test.done && !i_test.fail && !i_driver_up; endsequence
   a_reset_dark: assert property ($rose(i_rstn) |-> &o_chan_hiz && o_chan_led == '0)
      else $error("Outputs not dark after reset.");
   a_code_shown: assert property (test_r && i_test.running && !i_test.fail && !i_test.done
      |=> o_diag_led == $past(i_test.code)) else $error("Test code not shown.");
   a_halt_frozen: assert property (s_fail |=> o_diag_led == $past(i_test.code)
      ##1 $stable(o_diag_led)[*8]) else $error("Failing code not held.");
   a_rot_start: assert property (s_pass |=> o_diag_led == 8'h01
      ##[1:ROT_MAX] o_diag_led == 8'h02) else $error("Rotation did not step.");
   a_beat_period: assert property (!o_chan_hiz[0] && run_r >= 2 * BEAT_CYC
      && $changed(o_diag_led[0]) |-> cnt_r == BEAT_CYC - 1) else $error("Heartbeat period wrong.");
   a_run_status: assert property (!o_chan_hiz[0]
      |-> o_diag_led[2:1] == $past({i_irq_pending, i_cmd_busy})) else $error("Status lamps wrong.");
   a_async_any: assert property (!o_chan_hiz[0]
      |-> o_diag_led[4:3] == $past({any[3], any[4]})) else $error("Async lamps wrong.");
   a_sync_any: assert property (!o_chan_hiz[0]
      |-> o_diag_led[6:5] == $past({any[1], any[2]})) else $error("Sync lamps wrong.");
   a_rxerr_any: assert property (!o_chan_hiz[0] |-> o_diag_led[7] == $past(any[0]))
      else $error("Receive error lamp wrong.");
   a_hiz_dark: assert property (&o_chan_hiz |-> o_chan_led == '0)
      else $error("Lamps lit in high impedance.");
endmodule : bsl_chk
bind bsl_indicator bsl_chk #(.NCH(NCH), .BEAT_CYC(BEAT_CYC), .ROT_CYC(ROT_CYC)) chk_u (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_test(i_test), .i_driver_up(i_driver_up),
   .i_cmd_busy(i_cmd_busy), .i_irq_pending(i_irq_pending), .i_chan_act(i_chan_act),
   .o_diag_led(o_diag_led), .o_chan_led(o_chan_led), .o_chan_hiz(o_chan_hiz));

// ===== dv/tb.sv
// Self-checking bench for the indicator block.
`timescale 1ns/1ns
module tb;
   import bsl_pkg::*;
   typedef struct {int cyc; logic [43:0] m; logic [43:0] v;} bsl_note_t;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   bsl_test_t i_test = '0;
   logic i_driver_up = 1'b0;
   logic i_cmd_busy = 1'b0;
   logic i_irq_pending = 1'b0;
   bsl_chan_act_t [3:0] i_chan_act = '0;
   bsl_if_t [3:0] i_chan_if = {4{BSL_IF_HIZ}};
   logic [7:0] o_diag_led;
   logic [3:0][7:0] o_chan_led;
   logic [3:0] o_chan_hiz;
   logic [7:0] pat [5] = '{8'h00, 8'h22, 8'hEE, 8'h44, 8'h05};
   logic [7:0] codes [7] = '{8'h01, 8'h1A, 8'hC0, 8'hC2, 8'hC4, 8'h81, 8'h8F};
   localparam logic [43:0] MD = 44'hFF0_0000_000F;
   bsl_note_t q [$];
   int err_count = 0;
   int n_tests = 0;
   int ncyc = 0;
   logic [7:0] seen;
   bsl_indicator #(.NCH(4), .BEAT_CYC(4), .ROT_CYC(3)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_test(i_test), .i_driver_up(i_driver_up), .i_cmd_busy(i_cmd_busy),
      .i_irq_pending(i_irq_pending), .i_chan_act(i_chan_act), .i_chan_if(i_chan_if),
      .o_diag_led(o_diag_led), .o_chan_led(o_chan_led), .o_chan_hiz(o_chan_hiz));
   always #4 i_clk = ~i_clk;
   task automatic check(input logic [43:0] got, input logic [43:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic note(input int d, input logic [43:0] m, input logic [43:0] v);
      q.push_back('{ncyc + d, m, v});
   endtask : note
   task automatic tally_and_finish;
      $display("TB: checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(negedge i_clk) begin
      ncyc++;
      while (q.size() > 0 && q[0].cyc <= ncyc) begin
         check({o_diag_led, o_chan_led, o_chan_hiz} & q[0].m, q[0].v);
         void'(q.pop_front());
      end
      if (ncyc > 2000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'h633c));
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      note(1, '1, 44'hF);
      foreach (codes[k]) begin
         @(posedge i_clk);
         i_test <= '{1'b1, 1'b0, 1'b0, codes[k]};
         i_chan_if[2] <= bsl_if_t'(3'($urandom_range(4, 1)));
         note(2, '1, {codes[k], 36'hF});
      end
      @(posedge i_clk);
      i_test <= '{1'b1, 1'b1, 1'b0, 8'hC2};
      note(2, MD, {8'hC2, 36'hF});
      @(posedge i_clk);
      i_test <= '{1'b0, 1'b0, 1'b1, 8'h55};
      for (int k = 2; k < 10; k++) note(k, MD, {8'hC2, 36'hF});
      repeat (9) @(posedge i_clk);
      i_rstn <= 1'b0;
      i_test <= '0;
      repeat (3) @(posedge i_clk);
      i_rstn <= 1'b1;
      note(1, '1, 44'hF);
      @(posedge i_clk);
      i_test <= '{1'b0, 1'b0, 1'b1, 8'h00};
      @(posedge i_clk);
      seen = 8'h00;
      repeat (30) begin
         @(negedge i_clk);
         check(44'({$onehot(o_diag_led), o_chan_led, o_chan_hiz}), {8'h01, 36'hF});
         seen |= o_diag_led;
      end
      check(44'(seen), 44'hFF);
      @(posedge i_clk);
      i_driver_up <= 1'b1;
      note(3, 44'h010_0000_0000, 44'h010_0000_0000);
      repeat (48) begin : run
         bsl_if_t f;
         bsl_chan_act_t a;
         logic [4:0] any;
         logic [43:0] v;
         logic [1:0] b;
         @(posedge i_clk);
         any = '0;
         b = 2'($urandom);
         v = '0;
         for (int c = 0; c < 4; c++) begin
            f = bsl_if_t'(3'($urandom_range(4, c == 0 ? 1 : 0)));
            a = bsl_chan_act_t'(5'($urandom));
            any |= a;
            i_chan_if[c] <= f;
            i_chan_act[c] <= a;
            v[4 + 8 * c +: 8] = pat[f];
            v[c] = (f == BSL_IF_HIZ);
         end
         i_cmd_busy <= b[0];
         i_irq_pending <= b[1];
         v[43:37] = {any[0], any[1], any[2], any[3], any[4], b[1], b[0]};
         note(2, 44'hFEF_FFFF_FFFF, v);
      end
      repeat (3) @(posedge i_clk);
      tally_and_finish();
   end
endmodule : tb
